// [hdl/fsp_defs.svh]
// register map, field positions, reset values and counts of the framed serial port
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

`define FSP_ADDR_CTRL 8'h00
`define FSP_ADDR_TXDATA 8'h04
`define FSP_ADDR_RXDATA 8'h08
`define FSP_ADDR_STAT 8'h0c
`define FSP_ADDR_SLOT 8'h10

`define FSP_CTRL_EN 0
`define FSP_CTRL_CLKSRC 1
`define FSP_CTRL_TXDIR 2
`define FSP_CTRL_SLOT 3
`define FSP_CTRL_RXLVL 4
`define FSP_CTRL_TXLVL 5

`define FSP_STAT_TXPEND 0
`define FSP_STAT_TXBUSY 1
`define FSP_STAT_RXFULL 2
`define FSP_STAT_RXOVR 3

`define FSP_WORD_BITS 16
`define FSP_ADDR_BITS 8
`define FSP_CNT_W 5
`define FSP_TX_LAST 5'h0f
`define FSP_RX_LOAD 5'h10
`define FSP_DIV_HALF_LAST 2'h1
`define FSP_PIN_COUNT 8
`define FSP_SLOT_RESET 8'h00

`endif

// [hdl/fsp_pkg.sv]
// types of the framed serial port
package fsp_pkg;
`include "fsp_defs.svh"

    typedef enum logic [2:0] {
        FSP_TX_IDLE = 3'b001,
        FSP_TX_SYNC = 3'b010,
        FSP_TX_SHIFT = 3'b100
    } fsp_tx_state_t;

    typedef struct packed {
        logic ctrl_en;
        logic ctrl_clksrc;
        logic ctrl_txdir;
        logic ctrl_slot;
        logic [`FSP_ADDR_BITS-1:0] slot_addr;
        logic [`FSP_WORD_BITS-1:0] tx_data;
        logic tx_pend;
        fsp_tx_state_t tx_st;
        logic [`FSP_WORD_BITS-1:0] tx_sr;
        logic [`FSP_ADDR_BITS-1:0] addr_sr;
        logic [`FSP_CNT_W-1:0] tx_cnt;
        logic [`FSP_WORD_BITS-1:0] rx_sr;
        logic [`FSP_ADDR_BITS-1:0] rx_addr_sr;
        logic [`FSP_WORD_BITS-1:0] rx_data;
        logic [`FSP_ADDR_BITS-1:0] rx_addr;
        logic [`FSP_CNT_W-1:0] rx_cnt;
        logic rx_full;
        logic rx_ovr;
        logic [1:0] div_cnt;
        logic int_clk;
        logic tx_clk_prev;
        logic rx_clk_prev;
        logic tx_fs_prev;
        logic rx_fs_prev;
        logic pin_dout;
        logic pin_dout_oe;
        logic pin_txclk;
        logic pin_txclk_oe;
        logic pin_txfs;
        logic pin_txfs_oe;
        logic pin_rxfs;
        logic pin_rxfs_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fsp_state_t;
endpackage

// [hdl/fsp_sync.sv]
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module fsp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fsp_sync_state_t;

    fsp_sync_state_t s_r;
    fsp_sync_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = din;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.s2;
endmodule
`default_nettype wire

// [hdl/fsp_port.sv]
// framed serial port: apb registers, bit clocks, frame syncs, shift registers, output float
// Function
// (RULE_01) receive bits shift in on external receive clock
// (RULE_02) receive clock level readable in control register
// (RULE_03) clock select clear: transmit clock is input
// (RULE_04) clock select set: drive transmit clock, core/4
// (RULE_05) transmit clock level readable in control register
// (RULE_06) transmit shift register drives serial data out
// (RULE_07) data out floats when idle or off
// (RULE_08) clock, frame sync, address pins float when off
// (RULE_09) receive frame sync fall starts receive shifting
// (RULE_10) slot mode: receive sync pin carries address
// (RULE_11) transmit frame sync fall starts transmit shifting
// (RULE_12) transmit sync is input until direction bit set
// (RULE_13) slot mode: transmit sync pin carries frame pulse
// (RULE_14) float entered: test reset low, pin a high, b low
// (RULE_15) float condition only for test, never bus sharing
// (RULE_16) sixteen-bit words, one per frame sync
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fsp_port
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive pins
    input wire logic rx_bit_clock,
    input wire logic serial_data_in,
    input wire logic rx_frame_sync_i,
    output logic rx_frame_sync_o,
    output logic rx_frame_sync_oe,
    // transmit pins
    input wire logic tx_bit_clock_i,
    output logic tx_bit_clock_o,
    output logic tx_bit_clock_oe,
    input wire logic tx_frame_sync_i,
    output logic tx_frame_sync_o,
    output logic tx_frame_sync_oe,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    // test control pins
    input wire logic test_reset,
    input wire logic emulation_pin_a,
    input wire logic emulation_pin_b
);
    fsp_state_t s_r;
    fsp_state_t s_nxt;

    logic [`FSP_PIN_COUNT-1:0] pins_sync;
    logic rxclk_s;
    logic sdi_s;
    logic rxfs_s;
    logic txclk_s;
    logic txfs_s;
    logic trst_s;
    logic emu_a_s;
    logic emu_b_s;

    logic off_now;
    logic txclk_lvl;
    logic tx_rise;
    logic tx_fs_lvl;
    logic tx_fs_fall;
    logic rx_fall;
    logic rx_fs_lvl;
    logic rx_fs_fall;
    logic apb_setup;
    logic apb_access;

    // every pin passes two flops before use
    fsp_sync #(
        .W(`FSP_PIN_COUNT)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({rx_bit_clock, serial_data_in, rx_frame_sync_i, tx_bit_clock_i,
              tx_frame_sync_i, test_reset, emulation_pin_a, emulation_pin_b}),
        .dout(pins_sync)
    );

    assign {rxclk_s, sdi_s, rxfs_s, txclk_s, txfs_s, trst_s, emu_a_s, emu_b_s} = pins_sync;

    assign off_now = !trst_s && emu_a_s && !emu_b_s; // RULE_14
    assign txclk_lvl = s_r.ctrl_clksrc ? s_r.int_clk : txclk_s; // RULE_03 RULE_04
    assign tx_rise = txclk_lvl && !s_r.tx_clk_prev;
    // device owns frame sync when direction bit or slot mode is set
    assign tx_fs_lvl = (s_r.ctrl_txdir || s_r.ctrl_slot) ? s_r.pin_txfs : txfs_s; // RULE_12
    assign tx_fs_fall = s_r.tx_fs_prev && !tx_fs_lvl;
    assign rx_fall = !rxclk_s && s_r.rx_clk_prev; // RULE_01
    // in slot mode the frame pulse also frames the receiver
    assign rx_fs_lvl = s_r.ctrl_slot ? tx_fs_lvl : rxfs_s;
    assign rx_fs_fall = s_r.rx_fs_prev && !rx_fs_lvl;
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && s_r.pready;

    always_comb begin
        s_nxt = s_r;

        // apb: answer in the first access cycle
        s_nxt.pready = apb_setup;
        s_nxt.pslverr = 1'b0;
        if (apb_setup) begin
            s_nxt.prdata = 32'h0;
            unique case (paddr)
                `FSP_ADDR_CTRL: begin
                    s_nxt.prdata[`FSP_CTRL_EN] = s_r.ctrl_en;
                    s_nxt.prdata[`FSP_CTRL_CLKSRC] = s_r.ctrl_clksrc;
                    s_nxt.prdata[`FSP_CTRL_TXDIR] = s_r.ctrl_txdir;
                    s_nxt.prdata[`FSP_CTRL_SLOT] = s_r.ctrl_slot;
                    s_nxt.prdata[`FSP_CTRL_RXLVL] = rxclk_s; // RULE_02
                    s_nxt.prdata[`FSP_CTRL_TXLVL] = txclk_s; // RULE_05
                end
                `FSP_ADDR_TXDATA: begin
                    s_nxt.prdata[`FSP_WORD_BITS-1:0] = s_r.tx_data;
                end
                `FSP_ADDR_RXDATA: begin
                    s_nxt.prdata[`FSP_WORD_BITS-1:0] = s_r.rx_data;
                end
                `FSP_ADDR_STAT: begin
                    s_nxt.prdata[`FSP_STAT_TXPEND] = s_r.tx_pend;
                    s_nxt.prdata[`FSP_STAT_TXBUSY] = (s_r.tx_st != FSP_TX_IDLE);
                    s_nxt.prdata[`FSP_STAT_RXFULL] = s_r.rx_full;
                    s_nxt.prdata[`FSP_STAT_RXOVR] = s_r.rx_ovr;
                end
                `FSP_ADDR_SLOT: begin
                    s_nxt.prdata[`FSP_ADDR_BITS-1:0] = s_r.slot_addr;
                    s_nxt.prdata[2*`FSP_ADDR_BITS-1:`FSP_ADDR_BITS] = s_r.rx_addr;
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_access && pwrite) begin
            unique case (paddr)
                `FSP_ADDR_CTRL: begin
                    s_nxt.ctrl_en = pwdata[`FSP_CTRL_EN];
                    s_nxt.ctrl_clksrc = pwdata[`FSP_CTRL_CLKSRC];
                    s_nxt.ctrl_txdir = pwdata[`FSP_CTRL_TXDIR];
                    s_nxt.ctrl_slot = pwdata[`FSP_CTRL_SLOT];
                end
                `FSP_ADDR_TXDATA: begin
                    s_nxt.tx_data = pwdata[`FSP_WORD_BITS-1:0];
                    s_nxt.tx_pend = 1'b1;
                end
                `FSP_ADDR_SLOT: begin
                    s_nxt.slot_addr = pwdata[`FSP_ADDR_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
        // reading the word frees the holding register; a new word below wins
        if (apb_access && !pwrite && paddr == `FSP_ADDR_RXDATA) begin
            s_nxt.rx_full = 1'b0;
            s_nxt.rx_ovr = 1'b0;
        end

        // internal bit clock at a quarter of the core clock
        s_nxt.div_cnt = s_r.div_cnt + 2'h1;
        if (s_r.div_cnt == `FSP_DIV_HALF_LAST) begin // RULE_04
            s_nxt.div_cnt = 2'h0;
            s_nxt.int_clk = !s_r.int_clk;
        end

        // transmitter: data changes on rising bit clock edges
        s_nxt.tx_clk_prev = txclk_lvl;
        if (tx_rise) begin
            s_nxt.tx_fs_prev = tx_fs_lvl;
            if (tx_fs_fall && s_r.ctrl_en && s_r.tx_st != FSP_TX_SHIFT) begin // RULE_11 RULE_16
                s_nxt.tx_sr = s_r.tx_data;
                s_nxt.addr_sr = s_r.slot_addr;
                s_nxt.tx_pend = apb_access && pwrite && paddr == `FSP_ADDR_TXDATA;
                s_nxt.tx_cnt = `FSP_TX_LAST;
                s_nxt.tx_st = FSP_TX_SHIFT;
                s_nxt.pin_txfs = 1'b1;
            end else begin
                unique case (s_r.tx_st)
                    FSP_TX_IDLE: begin
                        // own frame sync: one bit clock low pulse
                        if (s_r.ctrl_en && s_r.tx_pend && (s_r.ctrl_txdir || s_r.ctrl_slot)) begin // RULE_13
                            s_nxt.pin_txfs = 1'b0;
                            s_nxt.tx_st = FSP_TX_SYNC;
                        end
                    end
                    FSP_TX_SYNC: begin
                        // frame given up if the direction changed meanwhile
                        s_nxt.pin_txfs = 1'b1;
                        s_nxt.tx_st = FSP_TX_IDLE;
                    end
                    FSP_TX_SHIFT: begin
                        if (s_r.tx_cnt == `FSP_CNT_W'(0)) begin
                            s_nxt.tx_st = FSP_TX_IDLE;
                        end else begin
                            s_nxt.tx_sr = {s_r.tx_sr[`FSP_WORD_BITS-2:0], 1'b0}; // RULE_06
                            s_nxt.addr_sr = {s_r.addr_sr[`FSP_ADDR_BITS-2:0], 1'b0}; // RULE_10
                            s_nxt.tx_cnt = s_r.tx_cnt - `FSP_CNT_W'(1);
                        end
                    end
                endcase
            end
        end

        // receiver: data and frame sync sampled on falling bit clock edges
        s_nxt.rx_clk_prev = rxclk_s;
        if (rx_fall) begin
            s_nxt.rx_fs_prev = rx_fs_lvl;
            if (s_r.rx_cnt != `FSP_CNT_W'(0)) begin
                s_nxt.rx_sr = {s_r.rx_sr[`FSP_WORD_BITS-2:0], sdi_s}; // RULE_01
                s_nxt.rx_addr_sr = {s_r.rx_addr_sr[`FSP_ADDR_BITS-2:0], rxfs_s}; // RULE_10
                s_nxt.rx_cnt = s_r.rx_cnt - `FSP_CNT_W'(1);
                if (s_r.rx_cnt == `FSP_CNT_W'(1)) begin // RULE_16
                    s_nxt.rx_data = {s_r.rx_sr[`FSP_WORD_BITS-2:0], sdi_s};
                    if (s_r.ctrl_slot) begin
                        s_nxt.rx_addr = s_r.rx_addr_sr;
                    end
                    s_nxt.rx_ovr = s_r.rx_full || (s_r.rx_ovr && s_nxt.rx_ovr);
                    s_nxt.rx_full = 1'b1;
                end
            end else if (rx_fs_fall && s_r.ctrl_en) begin // RULE_09
                s_nxt.rx_cnt = `FSP_RX_LOAD;
            end
        end

        // data and address pin drivers follow the next state, clock pin and clock/sync enables the current one; all floated while off
        s_nxt.pin_dout = s_nxt.tx_sr[`FSP_WORD_BITS-1]; // RULE_06
        s_nxt.pin_dout_oe = (s_nxt.tx_st == FSP_TX_SHIFT) && !off_now; // RULE_07
        s_nxt.pin_txclk = s_r.int_clk;
        s_nxt.pin_txclk_oe = s_r.ctrl_clksrc && !off_now; // RULE_03 RULE_04 RULE_08
        s_nxt.pin_txfs_oe = (s_r.ctrl_txdir || s_r.ctrl_slot) && !off_now; // RULE_08 RULE_12 RULE_13
        s_nxt.pin_rxfs = s_nxt.addr_sr[`FSP_ADDR_BITS-1];
        s_nxt.pin_rxfs_oe = s_r.ctrl_slot && (s_nxt.tx_st == FSP_TX_SHIFT) && !off_now; // RULE_08 RULE_10
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.tx_st <= FSP_TX_IDLE;
            s_r.slot_addr <= `FSP_SLOT_RESET;
            s_r.pin_txfs <= 1'b1;
            s_r.tx_fs_prev <= 1'b1;
            s_r.rx_fs_prev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign rx_frame_sync_o = s_r.pin_rxfs;
    assign rx_frame_sync_oe = s_r.pin_rxfs_oe;
    assign tx_bit_clock_o = s_r.pin_txclk;
    assign tx_bit_clock_oe = s_r.pin_txclk_oe;
    assign tx_frame_sync_o = s_r.pin_txfs;
    assign tx_frame_sync_oe = s_r.pin_txfs_oe;
    assign serial_data_out = s_r.pin_dout;
    assign serial_data_out_oe = s_r.pin_dout_oe;

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_float_all;
        off_now |=> !serial_data_out_oe && !tx_bit_clock_oe && !tx_frame_sync_oe && !rx_frame_sync_oe;
    endproperty
    a_float_all: assert property (p_float_all) else $error("driver active while off"); // RULE_08

    property p_txclk_input;
        !s_r.ctrl_clksrc |=> !tx_bit_clock_oe;
    endproperty
    a_txclk_input: assert property (p_txclk_input) else $error("tx clock driven while input"); // RULE_03

    property p_txclk_quarter;
        $rose(s_r.int_clk) |-> s_r.int_clk [*2] ##1 !s_r.int_clk [*2] ##1 s_r.int_clk;
    endproperty
    a_txclk_quarter: assert property (p_txclk_quarter) else $error("internal clock not core/4"); // RULE_04

    property p_txclk_driven;
        s_r.ctrl_clksrc && !off_now |=> tx_bit_clock_oe && tx_bit_clock_o == $past(s_r.int_clk);
    endproperty
    a_txclk_driven: assert property (p_txclk_driven) else $error("tx clock not driven"); // RULE_04

    property p_fs_input;
        !(s_r.ctrl_txdir || s_r.ctrl_slot) |=> !tx_frame_sync_oe;
    endproperty
    a_fs_input: assert property (p_fs_input) else $error("frame sync driven while input"); // RULE_12

    property p_rx_level;
        apb_setup && !pwrite && paddr == `FSP_ADDR_CTRL |=> pready && prdata[`FSP_CTRL_RXLVL] == $past(rxclk_s);
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("receive clock level wrong"); // RULE_02

    property p_tx_start;
        tx_rise && tx_fs_fall && s_r.ctrl_en && s_r.tx_st != FSP_TX_SHIFT && !off_now
            |=> s_r.tx_st == FSP_TX_SHIFT && s_r.tx_cnt == `FSP_TX_LAST && serial_data_out_oe;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("transmit did not start"); // RULE_11

    property p_dout_idle;
        s_r.tx_st != FSP_TX_SHIFT |-> !serial_data_out_oe;
    endproperty
    a_dout_idle: assert property (p_dout_idle) else $error("data out driven while idle"); // RULE_07

    property p_tx_shift;
        tx_rise && s_r.tx_st == FSP_TX_SHIFT && s_r.tx_cnt != `FSP_CNT_W'(0)
            |=> serial_data_out == $past(s_r.tx_sr[`FSP_WORD_BITS-2]);
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("wrong bit shifted out"); // RULE_06

    property p_rx_word;
        rx_fall && s_r.rx_cnt == `FSP_CNT_W'(1)
            |=> s_r.rx_full && s_r.rx_data == $past({s_r.rx_sr[`FSP_WORD_BITS-2:0], sdi_s});
    endproperty
    a_rx_word: assert property (p_rx_word) else $error("received word lost"); // RULE_09

    property p_slot_pulse;
        s_r.ctrl_slot && !off_now |=> tx_frame_sync_oe;
    endproperty
    a_slot_pulse: assert property (p_slot_pulse) else $error("frame pulse pin not driven"); // RULE_13

    property p_slot_addr;
        s_r.ctrl_slot && s_nxt.tx_st == FSP_TX_SHIFT && !off_now |=> rx_frame_sync_oe;
    endproperty
    a_slot_addr: assert property (p_slot_addr) else $error("address pin not driven"); // RULE_10
endmodule
`default_nettype wire

// [verif/fsp_codec_model.sv]
// far-side codec model: link clocks, frame syncs, receive data, capture of port outputs
`timescale 1ns/1ps
`default_nettype none
module fsp_codec_model (
    // sampling clock
    input wire logic clk_sys,
    // pins toward the port
    output logic rx_clk,
    output logic rx_fs,
    output logic rx_sd,
    output logic tx_clk,
    output logic tx_fs,
    // pins from the port
    input wire logic sd_out,
    input wire logic sd_out_oe,
    input wire logic addr_out,
    input wire logic addr_out_oe
);
    logic sd_q[$];
    logic addr_q[$];
    initial begin
        rx_clk = 1'b1;
        rx_fs = 1'b1;
        rx_sd = 1'b0;
        tx_clk = 1'b0;
        tx_fs = 1'b1;
    end
    // record what the port drives, cycle by cycle
    always @(posedge clk_sys) begin
        if (sd_out_oe === 1'b1) begin
            sd_q.push_back(sd_out);
        end
        if (addr_out_oe === 1'b1) begin
            addr_q.push_back(addr_out);
        end
    end
    task automatic set_levels(input logic rc, input logic tc);
        rx_clk = rc;
        tx_clk = tc;
    endtask
    // sync falls before the first falling edge, then 16 bits msb first
    task automatic send_word(input logic [15:0] w);
        #47;
        rx_fs = 1'b0;
        #40;
        for (int i = 15; i >= -1; i--) begin
            rx_clk = 1'b0;
            #80;
            rx_clk = 1'b1;
            rx_fs = 1'b1;
            rx_sd = (i >= 0) ? w[i & 15] : ~rx_sd;
            #80;
        end
    endtask
    // running transmit clock with one sync low period
    task automatic send_tx_frame();
        #7;
        for (int i = 0; i < 20; i++) begin
            tx_clk = 1'b1;
            #80;
            tx_clk = 1'b0;
            tx_fs = (i == 1) ? 1'b0 : 1'b1;
            #80;
        end
    endtask
endmodule
`default_nettype wire

// [verif/test_framed_serial_port_pins.sv]
// self-checking testbench of the framed serial port
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module test_framed_serial_port_pins;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic test_reset = 1'b1, pin_a = 1'b0, pin_b = 1'b1;
    logic rx_fs_o, rx_fs_oe, tx_clk_o, tx_clk_oe, tx_fs_o, tx_fs_oe, sd_out, sd_oe;
    logic c_rx_clk, c_rx_fs, c_rx_sd, c_tx_clk, c_tx_fs;
    logic [31:0] lfsr_r = 32'h99ba;
    logic [15:0] tx_model[$];
    logic [15:0] rx_model[$];
    logic [31:0] q;
    logic e, fs_prev;
    int err_count = 0, tests_run = 0, fs_falls = 0, f0, rises;
    wire rx_fs_w = rx_fs_oe ? rx_fs_o : c_rx_fs;
    wire tx_clk_w = tx_clk_oe ? tx_clk_o : c_tx_clk;
    wire tx_fs_w = tx_fs_oe ? tx_fs_o : c_tx_fs;

    always #10 clk_sys = ~clk_sys;

    fsp_port u_fsp_port (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_bit_clock(c_rx_clk), .serial_data_in(c_rx_sd), .rx_frame_sync_i(rx_fs_w),
        .rx_frame_sync_o(rx_fs_o), .rx_frame_sync_oe(rx_fs_oe), .tx_bit_clock_i(tx_clk_w),
        .tx_bit_clock_o(tx_clk_o), .tx_bit_clock_oe(tx_clk_oe), .tx_frame_sync_i(tx_fs_w),
        .tx_frame_sync_o(tx_fs_o), .tx_frame_sync_oe(tx_fs_oe), .serial_data_out(sd_out),
        .serial_data_out_oe(sd_oe), .test_reset(test_reset), .emulation_pin_a(pin_a),
        .emulation_pin_b(pin_b));

    fsp_codec_model u_fsp_codec_model (.clk_sys(clk_sys), .rx_clk(c_rx_clk), .rx_fs(c_rx_fs),
        .rx_sd(c_rx_sd), .tx_clk(c_tx_clk), .tx_fs(c_tx_fs), .sd_out(sd_out), .sd_out_oe(sd_oe),
        .addr_out(rx_fs_o), .addr_out_oe(rx_fs_oe));

    // device-driven frame pulses
    always @(posedge clk_sys) begin
        fs_prev <= tx_fs_o;
        if (tx_fs_oe === 1'b1 && fs_prev === 1'b1 && tx_fs_o === 1'b0) begin
            fs_falls++;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check({31'h0, e}, 32'h0, "write error");
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        check({31'h0, e}, 32'h0, "read error");
    endtask

    task automatic send_tx(input logic [15:0] w);
        tx_model.push_back(w);
        wr(`FSP_ADDR_TXDATA, {16'h0, w});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `FSP_ADDR_STAT, 32'h0);
            n++;
        end while (q[1:0] !== 2'b00 && n < 200);
        if (q[1:0] !== 2'b00) begin
            err_count++;
            $display("Error at %0t: port never went idle", $time);
        end
        tick(4);
    endtask

    task automatic take_word(ref logic bq[$], input int p, output logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            w[i] = bq[p / 2];
            repeat (p) void'(bq.pop_front());
        end
    endtask

    // p: system clocks per serial bit
    task automatic check_tx(input int p);
        logic [15:0] w;
        check(32'(u_fsp_codec_model.sd_q.size()), 32'(tx_model.size() * 16 * p), "tx samples");
        if (u_fsp_codec_model.sd_q.size() == tx_model.size() * 16 * p) begin
            while (tx_model.size() > 0) begin
                take_word(u_fsp_codec_model.sd_q, p, w);
                check({16'h0, w}, {16'h0, tx_model.pop_front()}, "tx word");
            end
        end
        u_fsp_codec_model.sd_q.delete();
        tx_model.delete();
    endtask

    task automatic note(input string n);
        $display("test %s done", n);
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial begin
        logic [15:0] w;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({30'h0, tx_clk_oe, tx_fs_oe}, 32'h0, "oe after reset");
        tick(2);
        rd(`FSP_ADDR_CTRL);
        check(q, 32'h10, "ctrl reset");
        rd(`FSP_ADDR_STAT);
        check(q, 32'h0, "stat reset");
        rd(`FSP_ADDR_SLOT);
        check(q, 32'h0, "slot reset");
        wr(`FSP_ADDR_STAT, 32'hf);
        rd(`FSP_ADDR_STAT);
        check(q, 32'h0, "stat read only");
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped data");
        note("registers");
        for (int l = 0; l < 4; l++) begin
            u_fsp_codec_model.set_levels(l[0], l[1]);
            tick(5);
            rd(`FSP_ADDR_CTRL);
            check({30'h0, q[5:4]}, 32'(l), "pin levels");
        end
        note("levels");
        wr(`FSP_ADDR_CTRL, 32'h1);
        for (int k = 0; k < 3; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            w = lfsr_r[15:0];
            rx_model.push_back(w);
            u_fsp_codec_model.send_word(w);
            tick(8);
            rd(`FSP_ADDR_STAT);
            check({28'h0, q[3:0]}, (k == 2) ? 32'hc : 32'h4, "rx status");
            if (k != 1) begin
                rd(`FSP_ADDR_RXDATA);
                check(q, {16'h0, rx_model[rx_model.size() - 1]}, "rx word");
                rd(`FSP_ADDR_STAT);
                check({28'h0, q[3:0]}, 32'h0, "rx cleared");
            end
        end
        note("receive");
        lfsr_r = lfsr_next(lfsr_r);
        send_tx(lfsr_r[15:0]);
        check({31'h0, sd_oe}, 32'h0, "idle data float");
        u_fsp_codec_model.send_tx_frame();
        tick(10);
        check_tx(8);
        note("external transmit");
        wr(`FSP_ADDR_CTRL, 32'h7);
        tick(1);
        check({31'h0, tx_fs_oe}, 32'h1, "sync output");
        rises = 0;
        e = tx_clk_o;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            rises += (tx_clk_oe === 1'b1 && e === 1'b0 && tx_clk_o === 1'b1) ? 1 : 0;
            e = tx_clk_o;
        end
        check(32'(rises), 32'd10, "core clock quarter");
        f0 = fs_falls;
        lfsr_r = lfsr_next(lfsr_r);
        send_tx(lfsr_r[15:0]);
        wait_idle();
        lfsr_r = lfsr_next(lfsr_r);
        send_tx(lfsr_r[31:16]);
        wait_idle();
        check_tx(4);
        check(32'(fs_falls - f0), 32'd2, "frame pulses");
        note("internal transmit");
        send_tx(16'h8001);
        tick(12);
        test_reset <= 1'b0;
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        tick(6);
        check({29'h0, sd_oe, tx_clk_oe, tx_fs_oe}, 32'h0, "float mid word");
        test_reset <= 1'b1;
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        wait_idle();
        u_fsp_codec_model.sd_q.delete();
        tx_model.delete();
        for (int c = 0; c < 8; c++) begin
            test_reset <= c[2];
            pin_a <= c[1];
            pin_b <= c[0];
            tick(6);
            check({30'h0, tx_clk_oe, tx_fs_oe}, (c == 2) ? 32'h0 : 32'h3, "float combos");
        end
        note("float");
        wr(`FSP_ADDR_CTRL, 32'hb);
        wr(`FSP_ADDR_SLOT, 32'h5a);
        u_fsp_codec_model.addr_q.delete();
        send_tx(16'h1234);
        check({31'h0, tx_fs_oe}, 32'h1, "slot pulse output");
        wait_idle();
        check_tx(4);
        check(32'(u_fsp_codec_model.addr_q.size()), 32'd64, "address samples");
        if (u_fsp_codec_model.addr_q.size() == 64) begin
            take_word(u_fsp_codec_model.addr_q, 4, w);
            check({16'h0, w}, 32'h5a00, "slot address");
        end
        rd(`FSP_ADDR_SLOT);
        check({24'h0, q[7:0]}, 32'h5a, "slot readback");
        note("slot");
        end_of_test();
    end
endmodule
`default_nettype wire
